// >>> common/tcc_pkg.sv
package tcc_pkg;
	localparam logic [2:0] TCC_ADDR_COUNT = 3'h0;
	localparam logic [2:0] TCC_ADDR_CMP_A = 3'h1;
	localparam logic [2:0] TCC_ADDR_CMP_B = 3'h2;
	localparam logic [2:0] TCC_ADDR_CTRL_A = 3'h3;
	localparam logic [2:0] TCC_ADDR_CTRL_B = 3'h4;
	localparam logic [2:0] TCC_ADDR_FLAGS = 3'h5;
	localparam logic [2:0] TCC_ADDR_MASK = 3'h6;
	localparam logic [2:0] TCC_ADDR_PORT = 3'h7;
	// Control A: [7:6] pin action A, [5:4] pin action B, [1:0] wave_sel bits 1:0.
	localparam int TCC_CA_ACT_A = 6;
	localparam int TCC_CA_ACT_B = 4;
	// Control B: [7] force A, [6] force B, [3] wave_sel bit 2, [2:0] clock source.
	localparam int TCC_CB_FORCE_A = 7;
	localparam int TCC_CB_FORCE_B = 6;
	localparam int TCC_CB_WAVE2 = 3;
	// Flags and mask: [2] match B, [1] match A, [0] wrap.
	localparam int TCC_FL_WRAP = 0;
	localparam int TCC_FL_A = 1;
	localparam int TCC_FL_B = 2;
	// Port register: [3] dir B, [2] dir A, [1] data B, [0] data A.
	localparam logic [7:0] TCC_RESET_BYTE = 8'h00;
	localparam logic [7:0] TCC_MAX = 8'hff;
	localparam logic [7:0] TCC_BOTTOM = 8'h00;
	localparam logic [2:0] TCC_WAVE_NORMAL = 3'h0;
	localparam logic [2:0] TCC_WAVE_CLEAR = 3'h2;
	localparam logic [2:0] TCC_WAVE_FAST_MAX = 3'h3;
	localparam logic [2:0] TCC_WAVE_FAST_A = 3'h7;
	localparam logic [2:0] TCC_WAVE_PHASE_A = 3'h5;
	localparam logic [2:0] TCC_CS_STOP = 3'h0;
	localparam logic [1:0] TCC_ACT_NONE = 2'h0;
	localparam logic [1:0] TCC_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TCC_ACT_CLEAR = 2'h2;
	localparam logic [1:0] TCC_ACT_SET = 2'h3;
endpackage

// >>> logic/tcc_timer.sv
// Decided for this implementation: strobed register access and the register offsets.
module tcc_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic irq_ack_wrap_i,
	input wire logic irq_ack_a_i,
	input wire logic irq_ack_b_i,
	output logic irq_wrap_o,
	output logic irq_a_o,
	output logic irq_b_o,
	output logic wave_out_a_o,
	output logic wave_out_a_oe_o,
	output logic wave_out_b_o,
	output logic wave_out_b_oe_o
);
	// Counter and the two active compare values.
	logic [7:0] count_q;
	logic [7:0] cmp_a_q;
	logic [7:0] cmp_b_q;

	// Buffers that software writes; they reach the active values directly in the
	// non-PWM modes and only at the turning points of the count in the PWM modes.
	logic [7:0] buf_a_q;
	logic [7:0] buf_b_q;

	// Software visible control, port and read data registers.
	logic [7:0] ctrl_a_q;
	logic [7:0] ctrl_b_q;
	logic [7:0] port_q;
	logic [7:0] rdata_q;

	// Event flags, one register each, and their enable mask.
	logic flag_a_q;
	logic flag_b_q;
	logic flag_w_q;
	logic [2:0] flags;
	logic [2:0] mask_q;

	// Internal output states, the write block and the count direction.
	logic oc_a_q;
	logic oc_b_q;
	logic block_q;
	logic up_q;

	// Decoded control fields.
	logic [2:0] wave_sel;
	logic [1:0] act_a;
	logic [1:0] act_b;
	logic pwm;
	logic phase;

	// Timer clock qualifier and counter events.
	logic tclk;
	logic wr_count;
	logic top_hit;
	logic bottom_hit;

	// Compare events per unit.
	logic match_a;
	logic match_b;
	logic fire_a;
	logic fire_b;
	logic force_a;
	logic force_b;
	logic wrap;

	// Software clears of the flags, one per flag.
	logic clr_a;
	logic clr_b;
	logic clr_w;

	// Top of the count sequence and the counter's next value.
	logic [7:0] top_val;
	logic [7:0] count_d;

	function automatic logic apply_act(input logic [1:0] act, input logic cur);
		case (act)
			tcc_pkg::TCC_ACT_TOGGLE: apply_act = ~cur;
			tcc_pkg::TCC_ACT_CLEAR: apply_act = 1'b0;
			tcc_pkg::TCC_ACT_SET: apply_act = 1'b1;
			default: apply_act = cur;
		endcase
	endfunction

	assign wave_sel = {ctrl_b_q[tcc_pkg::TCC_CB_WAVE2], ctrl_a_q[1:0]};
	assign act_a = ctrl_a_q[tcc_pkg::TCC_CA_ACT_A +: 2];
	assign act_b = ctrl_a_q[tcc_pkg::TCC_CA_ACT_B +: 2];
	assign pwm = (wave_sel != tcc_pkg::TCC_WAVE_NORMAL) && (wave_sel != tcc_pkg::TCC_WAVE_CLEAR);
	assign phase = (wave_sel == 3'h1) || (wave_sel == tcc_pkg::TCC_WAVE_PHASE_A);
	// The external prescaler tick counts only when a clock source is chosen.
	assign tclk = en_i && tick_i && (ctrl_b_q[2:0] != tcc_pkg::TCC_CS_STOP);
	assign wr_count = en_i && wr_i && (addr_i == tcc_pkg::TCC_ADDR_COUNT);
	assign top_val = (wave_sel == tcc_pkg::TCC_WAVE_CLEAR || wave_sel == tcc_pkg::TCC_WAVE_FAST_A
		|| wave_sel == tcc_pkg::TCC_WAVE_PHASE_A) ? cmp_a_q : tcc_pkg::TCC_MAX;
	assign top_hit = (count_q == top_val);
	assign bottom_hit = (count_q == tcc_pkg::TCC_BOTTOM);
	assign match_a = (count_q == cmp_a_q) && !block_q;
	assign match_b = (count_q == cmp_b_q) && !block_q;
	assign fire_a = tclk && match_a;
	assign fire_b = tclk && match_b;
	assign force_a = en_i && wr_i && (addr_i == tcc_pkg::TCC_ADDR_CTRL_B)
		&& wdata_i[tcc_pkg::TCC_CB_FORCE_A] && !pwm;
	assign force_b = en_i && wr_i && (addr_i == tcc_pkg::TCC_ADDR_CTRL_B)
		&& wdata_i[tcc_pkg::TCC_CB_FORCE_B] && !pwm;

	// A one written to a flag position clears that flag; a zero leaves it alone.
	assign clr_w = en_i && wr_i && (addr_i == tcc_pkg::TCC_ADDR_FLAGS)
		&& wdata_i[tcc_pkg::TCC_FL_WRAP];
	assign clr_a = en_i && wr_i && (addr_i == tcc_pkg::TCC_ADDR_FLAGS)
		&& wdata_i[tcc_pkg::TCC_FL_A];
	assign clr_b = en_i && wr_i && (addr_i == tcc_pkg::TCC_ADDR_FLAGS)
		&& wdata_i[tcc_pkg::TCC_FL_B];
	assign flags = {flag_b_q, flag_a_q, flag_w_q};

	// Next count for one timer clock cycle.
	// The dual-slope branch turns at top and bottom under control of up_q.
	// Every single-slope mode other than Normal clears at its top value; Normal only ever
	// increments, so its top of 0xff simply wraps through the adder.
	// A compare A value written below the current count is therefore passed by and
	// only met again after the counter has wrapped through zero.
	always_comb begin
		count_d = count_q;
		if (phase) begin
			count_d = up_q ? (top_hit ? count_q - 8'h01 : count_q + 8'h01)
				: (bottom_hit ? count_q + 8'h01 : count_q - 8'h01);
		end else if (wave_sel != tcc_pkg::TCC_WAVE_NORMAL && top_hit) begin
			count_d = tcc_pkg::TCC_BOTTOM;
		end else begin
			count_d = count_q + 8'h01;
		end
	end
	assign wrap = tclk && !wr_count && (count_d == tcc_pkg::TCC_BOTTOM) && !phase
		&& (count_q == tcc_pkg::TCC_MAX || wave_sel == tcc_pkg::TCC_WAVE_FAST_A
		|| wave_sel == tcc_pkg::TCC_WAVE_FAST_MAX);

	// The counter register. A software write wins over any count or clear in the
	// same cycle, and it restarts the dual-slope direction upwards.
	// With the clock source at zero tclk never rises, so the count holds while
	// software can still read and write it.

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_q <= tcc_pkg::TCC_RESET_BYTE;
			up_q <= 1'b1;
		end else if (wr_count) begin
			count_q <= wdata_i;
			up_q <= 1'b1;
		end else if (tclk) begin
			count_q <= count_d;
			if (phase && top_hit)
				up_q <= 1'b0;
			else if (phase && bottom_hit)
				up_q <= 1'b1;
		end
	end

	// Block stays armed until the timer clock cycle after the write is consumed.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			block_q <= 1'b0;
		else if (wr_count)
			block_q <= 1'b1;
		else if (tclk)
			block_q <= 1'b0;
	end

	// Compare unit A. Software always writes the buffer. In Normal and clear-on-match
	// modes the active value follows at once, so a new top takes effect immediately.
	// In the PWM modes the active value only loads at the turning point of the count,
	// which keeps every PWM period whole and free of odd-length pulses.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_a_q <= tcc_pkg::TCC_RESET_BYTE;
			buf_a_q <= tcc_pkg::TCC_RESET_BYTE;
		end else if (en_i) begin
			if (wr_i && addr_i == tcc_pkg::TCC_ADDR_CMP_A) begin
				buf_a_q <= wdata_i;
				if (!pwm) begin
					cmp_a_q <= wdata_i;
				end
			end
			if (pwm && tclk && (phase ? top_hit : bottom_hit)) begin
				cmp_a_q <= buf_a_q;
			end
		end
	end

	// Compare unit B follows the same buffering scheme as unit A.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_b_q <= tcc_pkg::TCC_RESET_BYTE;
			buf_b_q <= tcc_pkg::TCC_RESET_BYTE;
		end else if (en_i) begin
			if (wr_i && addr_i == tcc_pkg::TCC_ADDR_CMP_B) begin
				buf_b_q <= wdata_i;
				if (!pwm) begin
					cmp_b_q <= wdata_i;
				end
			end
			if (pwm && tclk && (phase ? top_hit : bottom_hit)) begin
				cmp_b_q <= buf_b_q;
			end
		end
	end

	// Control, mask and port registers. The force bits of control B are strobes:
	// they act in the cycle of the write outside the PWM modes and are never stored, so they read as zero.
	// The pin action bits take effect from the next edge with no buffering.

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_a_q <= tcc_pkg::TCC_RESET_BYTE;
			ctrl_b_q <= tcc_pkg::TCC_RESET_BYTE;
			port_q <= tcc_pkg::TCC_RESET_BYTE;
			mask_q <= 3'h0;
		end else if (en_i && wr_i) begin
			case (addr_i)
				tcc_pkg::TCC_ADDR_CTRL_A: ctrl_a_q <= wdata_i;
				tcc_pkg::TCC_ADDR_CTRL_B: ctrl_b_q <= {2'h0, wdata_i[5:0]};
				tcc_pkg::TCC_ADDR_MASK: mask_q <= wdata_i[2:0];
				tcc_pkg::TCC_ADDR_PORT: port_q <= {4'h0, wdata_i[3:0]};
				default: ;
			endcase
		end
	end

	// Output states: a match, or a force outside the PWM modes, applies the pin action; single-slope PWM modes also act at top.
	// Output state A. In the non-PWM modes a real match and a force strobe share the
	// path through apply_act, so a force moves the state exactly as a match would.
	// The PWM branches act only while the upper pin action bit is set.
	// No branch reloads the state when the wave mode itself changes, so the state is
	// carried unchanged across a mode switch.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			oc_a_q <= 1'b0;
		end else if (force_a || (fire_a && !pwm)) begin
			oc_a_q <= apply_act(act_a, oc_a_q);
		end else if (fire_a && pwm && act_a[1]) begin
			oc_a_q <= phase ? (up_q ? ~act_a[0] : act_a[0]) : act_a[0];
		end else if (tclk && !phase && pwm && top_hit && act_a[1]) begin
			oc_a_q <= ~act_a[0];
		end
	end

	// Output state B, handled like output state A.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			oc_b_q <= 1'b0;
		end else if (force_b || (fire_b && !pwm)) begin
			oc_b_q <= apply_act(act_b, oc_b_q);
		end else if (fire_b && pwm && act_b[1]) begin
			oc_b_q <= phase ? (up_q ? ~act_b[0] : act_b[0]) : act_b[0];
		end else if (tclk && !phase && pwm && top_hit && act_b[1]) begin
			oc_b_q <= ~act_b[0];
		end
	end

	// Compare flag A. The match is taken on the timer clock cycle in which the count
	// equals the compare value, so the flag shows one edge later.
	// Service and a software one both clear it, but a match in the same cycle wins,
	// so an event that lands on a clear is never lost.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_a_q <= 1'b0;
		end else if (en_i) begin
			if (fire_a) begin
				flag_a_q <= 1'b1;
			end else if (irq_ack_a_i || clr_a) begin
				flag_a_q <= 1'b0;
			end
		end
	end

	// Compare flag B, with the same set and clear priority as flag A.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_b_q <= 1'b0;
		end else if (en_i) begin
			if (fire_b) begin
				flag_b_q <= 1'b1;
			end else if (irq_ack_b_i || clr_b) begin
				flag_b_q <= 1'b0;
			end
		end
	end

	// Wrap flag. It rises on the edge at which the count rolls from 0xff to zero outside the dual-slope modes, or a fast PWM mode clears to zero; like
	// a ninth counter bit that is only ever set by hardware.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_w_q <= 1'b0;
		end else if (en_i) begin
			if (wrap) begin
				flag_w_q <= 1'b1;
			end else if (irq_ack_wrap_i || clr_w) begin
				flag_w_q <= 1'b0;
			end
		end
	end

	// Read data register. It is loaded only by a read strobe and holds otherwise,
	// so the value stands in the cycle after the strobe and until the next read.
	// In PWM modes a compare read returns the buffer that software last wrote.

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= tcc_pkg::TCC_RESET_BYTE;
		end else if (en_i && rd_i) begin
			case (addr_i)
				tcc_pkg::TCC_ADDR_COUNT: rdata_q <= count_q;
				tcc_pkg::TCC_ADDR_CMP_A: rdata_q <= pwm ? buf_a_q : cmp_a_q;
				tcc_pkg::TCC_ADDR_CMP_B: rdata_q <= pwm ? buf_b_q : cmp_b_q;
				tcc_pkg::TCC_ADDR_CTRL_A: rdata_q <= ctrl_a_q;
				tcc_pkg::TCC_ADDR_CTRL_B: rdata_q <= ctrl_b_q;
				tcc_pkg::TCC_ADDR_FLAGS: rdata_q <= {5'h0, flags};
				tcc_pkg::TCC_ADDR_MASK: rdata_q <= {5'h0, mask_q};
				default: rdata_q <= {2'h0, oc_b_q, oc_a_q, port_q[3:0]};
			endcase
		end
	end

	assign rdata_o = rdata_q;

	// Interrupt requests are a flag gated by its enable; they fall as soon as the
	// flag is serviced or the enable is cleared.
	assign irq_a_o = flag_a_q && mask_q[tcc_pkg::TCC_FL_A];
	assign irq_b_o = flag_b_q && mask_q[tcc_pkg::TCC_FL_B];
	assign irq_wrap_o = flag_w_q && mask_q[tcc_pkg::TCC_FL_WRAP];

	// Pin override. Any nonzero pin action hands the pin value to the output state,
	// whatever the wave mode; the direction always stays with the port register.
	assign wave_out_a_o = (act_a != tcc_pkg::TCC_ACT_NONE) ? oc_a_q : port_q[0];
	assign wave_out_b_o = (act_b != tcc_pkg::TCC_ACT_NONE) ? oc_b_q : port_q[1];
	assign wave_out_a_oe_o = port_q[2];
	assign wave_out_b_oe_o = port_q[3];
endmodule

// >>> verification/tcc_tick_model.sv
module tcc_tick_model #(parameter int PERIOD = 4) (
	input wire logic clk_i,
	input wire logic run_i,
	output logic tick_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// Prescaler stand-in: a one-cycle timer clock pulse every PERIOD cycles while running.
	always @(posedge clk_i) begin
		cnt <= run_i ? (cnt + 1) % PERIOD : 0;
		tick_o <= run_i && cnt == PERIOD - 1;
	end
endmodule

// >>> verification/tcc_timer_monitor.sv
module tcc_timer_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic [2:0] addr_i,
	input wire logic wr_i,
	input wire logic irq_ack_wrap_i,
	input wire logic irq_ack_a_i,
	input wire logic irq_wrap_o,
	input wire logic irq_a_o,
	input wire logic wave_out_a_o,
	input wire logic wave_out_a_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_ack_a;
		!tick_i ##1 irq_ack_a_i && en_i && !tick_i && !wr_i;
	endsequence
	sequence s_ack_w;
		irq_ack_wrap_i && en_i && !tick_i && !wr_i;
	endsequence
	property p_rst;
		$fell(rst_i) |-> !wave_out_a_o && !wave_out_a_oe_o && !irq_a_o && !irq_wrap_o;
	endproperty
	property p_oe;
		$changed(wave_out_a_oe_o) |-> $past(wr_i && en_i && addr_i == tcc_pkg::TCC_ADDR_PORT);
	endproperty
	property p_out;
		$changed(wave_out_a_o) |-> $past(wr_i && en_i) || $past(tick_i) || $past(tick_i, 2);
	endproperty
	property p_wrap_rise;
		$rose(irq_wrap_o) |-> $past(tick_i) || $past(wr_i && addr_i == tcc_pkg::TCC_ADDR_MASK);
	endproperty
	property p_a_rise;
		$rose(irq_a_o) |-> $past(tick_i) || $past(tick_i, 2) || $past(wr_i);
	endproperty
	property p_a_fall;
		$fell(irq_a_o) |-> $past((irq_ack_a_i || wr_i) && en_i);
	endproperty
	property p_ack_a;
		s_ack_a |=> !irq_a_o;
	endproperty
	property p_ack_w;
		s_ack_w |=> !irq_wrap_o;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	a_oe: assert property (p_oe) else $error("pin direction changed without port write");
	a_out: assert property (p_out) else $error("pin value changed without cause");
	a_wrap_rise: assert property (p_wrap_rise) else $error("wrap request without tick");
	a_a_rise: assert property (p_a_rise) else $error("match A request without tick");
	a_a_fall: assert property (p_a_fall) else $error("match A request dropped alone");
	a_ack_a: assert property (p_ack_a) else $error("service did not clear flag A");
	a_ack_w: assert property (p_ack_w) else $error("service did not clear wrap");
endmodule
bind tcc_timer tcc_timer_monitor u_mon (.clk_i, .rst_i, .en_i, .tick_i, .addr_i, .wr_i,
	.irq_ack_wrap_i, .irq_ack_a_i, .irq_wrap_o, .irq_a_o, .wave_out_a_o, .wave_out_a_oe_o);

// >>> verification/tcc_timer_tb.sv
module tcc_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1, en_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, run = 1'b0;
	logic irq_ack_wrap_i = 1'b0, irq_ack_a_i = 1'b0, irq_ack_b_i = 1'b0, tick_i;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o;
	logic irq_wrap_o, irq_a_o, irq_b_o, wave_out_a_o, wave_out_a_oe_o;
	logic wave_out_b_o, wave_out_b_oe_o;
	int err_count = 0, comparisons = 0, n;
	always #4 clk_i = ~clk_i;
	tcc_tick_model #(.PERIOD(4)) u_tick (.clk_i, .run_i(run), .tick_o(tick_i));
	tcc_timer dut (.clk_i, .rst_i, .en_i, .tick_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.irq_ack_wrap_i, .irq_ack_a_i, .irq_ack_b_i, .irq_wrap_o, .irq_a_o, .irq_b_o,
		.wave_out_a_o, .wave_out_a_oe_o, .wave_out_b_o, .wave_out_b_oe_o);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o, e);
		@(posedge clk_i);
	endtask
	task automatic pin(input logic [7:0] e);
		@(negedge clk_i);
		chk({4'h0, wave_out_b_oe_o, wave_out_b_o, wave_out_a_oe_o, wave_out_a_o}, e);
		@(posedge clk_i);
	endtask
	task automatic wait_irq(input logic [2:0] m);
		for (n = 0; n < 3000 && ({irq_b_o, irq_a_o, irq_wrap_o} & m) !== m; n++)
			@(negedge clk_i);
		chk({5'h00, {irq_b_o, irq_a_o, irq_wrap_o} & m}, {5'h00, m});
		@(posedge clk_i);
	endtask
	// Counts cycles until the A pin value next changes.
	task automatic gap();
		logic v;
		v = wave_out_a_o;
		for (n = 0; n < 100 && wave_out_a_o === v; n++)
			@(negedge clk_i);
	endtask
	task automatic pulse_ack(input logic w);
		irq_ack_wrap_i <= w;
		irq_ack_a_i <= !w;
		@(posedge clk_i);
		irq_ack_wrap_i <= 1'b0;
		irq_ack_a_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wrap_up();
		if (err_count == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
	// Map: 0 count, 1 cmp A, 2 cmp B, 3 ctrl A, 4 ctrl B, 5 flags, 6 mask, 7 port.
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
		wr(3'h3, 8'hc0);
		wr(3'h4, 8'h80);
		rd(3'h7, 8'h10);
		rd(3'h5, 8'h00);
		rd(3'h0, 8'h00);
		wr(3'h7, 8'h04);
		pin(8'h03);
		wr(3'h3, 8'h02);
		pin(8'h02);
		rd(3'h7, 8'h14);
		wr(3'h3, 8'h00);
		wr(3'h4, 8'h80);
		rd(3'h7, 8'h14);
		wr(3'h3, 8'h40);
		wr(3'h4, 8'h80);
		rd(3'h7, 8'h04);
		pin(8'h02);
		wr(3'h3, 8'h00);
		wr(3'h6, 8'h07);
		wr(3'h1, 8'h80);
		rd(3'h1, 8'h80);
		wr(3'h2, 8'hfe);
		wr(3'h0, 8'hfe);
		rd(3'h0, 8'hfe);
		wr(3'h4, 8'h01);
		run <= 1'b1;
		wait_irq(3'h1);
		run <= 1'b0;
		wr(3'h4, 8'h00);
		rd(3'h5, 8'h01);
		rd(3'h0, 8'h00);
		wr(3'h5, 8'h06);
		rd(3'h5, 8'h01);
		pulse_ack(1'b1);
		rd(3'h5, 8'h00);
		wr(3'h3, 8'h42);
		wr(3'h1, 8'h03);
		wr(3'h0, 8'h00);
		wr(3'h4, 8'h01);
		run <= 1'b1;
		wait_irq(3'h2);
		pulse_ack(1'b0);
		chk({7'h00, irq_a_o}, 8'h00);
		gap();
		gap();
		chk(8'(n), 8'h10);
		gap();
		chk(8'(n), 8'h10);
		wait_irq(3'h2);
		run <= 1'b0;
		wr(3'h4, 8'h00);
		wr(3'h5, 8'h02);
		rd(3'h5, 8'h00);
		wr(3'h3, 8'h30);
		wr(3'h4, 8'h40);
		wr(3'h7, 8'h0c);
		pin(8'h0e);
		wr(3'h2, 8'h05);
		wr(3'h0, 8'h04);
		wr(3'h4, 8'h01);
		run <= 1'b1;
		wait_irq(3'h4);
		run <= 1'b0;
		wr(3'h4, 8'h00);
		rd(3'h5, 8'h04);
		wr(3'h5, 8'h04);
		rd(3'h5, 8'h00);
		wrap_up();
	end
endmodule
